// [rtl/rtcc_params.svh]
`ifndef RTCC_PARAMS_SVH
`define RTCC_PARAMS_SVH

// ----------------------------------------------------------------
// register map and reset values
// ----------------------------------------------------------------
`define RTCC_ADDR_CTL1 4'he
`define RTCC_ADDR_CTL2 4'hf
`define RTCC_CTL1_RST 8'h00
`define RTCC_RDATA_RST 8'h00

// ----------------------------------------------------------------
// crystal rates, tick counts and timing figures
// ----------------------------------------------------------------
`define RTCC_XTAL_HZ_HI 64'd32768
`define RTCC_XTAL_HZ_LO 64'd32000
`define RTCC_SEC_LAST_HI 16'h7fff
`define RTCC_SEC_LAST_LO 16'h7cff
`define RTCC_HALF_MS_HI 64'd500
`define RTCC_HALF_MS_LO 64'd496
`define RTCC_LAG_NS_HI 64'd92000
`define RTCC_LAG_NS_LO 64'd94000
`define RTCC_TRIM_PERIOD_S 5'd20
`define RTCC_ADJ_US_HI 122
`define RTCC_ADJ_US_LO 125

// ----------------------------------------------------------------
// time compare values
// ----------------------------------------------------------------
`define RTCC_SEC_HALF 7'h30
`define RTCC_BCD_ZERO7 7'h00
`define RTCC_HOUR_MID24 6'h00
`define RTCC_HOUR_MID12 6'h12
`define RTCC_DAY_FIRST 6'h01

`endif

// [rtl/rtcc_pkg.sv]
package rtcc_pkg;

    // periodic output selection codes
    typedef enum logic [2:0] {
        RTCC_PER_OFF = 3'h0,
        RTCC_PER_LOW = 3'h1,
        RTCC_PER_2HZ = 3'h2,
        RTCC_PER_1HZ = 3'h3,
        RTCC_PER_SEC = 3'h4,
        RTCC_PER_MIN = 3'h5,
        RTCC_PER_HOUR = 3'h6,
        RTCC_PER_MONTH = 3'h7
    } rtcc_per_t;

    // first control register layout
    typedef struct packed {
        logic alarm_a_enable;
        logic alarm_b_enable;
        logic route_sel_hi;
        logic route_sel_lo;
        logic test;
        rtcc_per_t periodic_sel;
    } rtcc_ctl1_t;

    // second control register layout; bit 4 is adjust on write
    typedef struct packed {
        logic [1:0] rsvd;
        logic fmt_24h;
        logic adj_or_halt;
        logic clkout_disable;
        logic periodic_flag;
        logic alarm_a_flag;
        logic alarm_b_flag;
    } rtcc_ctl2_t;

    // current counter values, bcd
    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [5:0] day;
    } rtcc_time_t;

endpackage : rtcc_pkg

// [rtl/rtcc_ctrl.sv]
// Overview of operation
// (RL1) first control register at Eh, halt clears
// (RL2) alarm enable gates its match action
// (RL3) routing code moves alarm B, periodic to B
// (RL4) single-output host writes routing bits zero
// (RL5) host keeps test bit zero
// (RL6) code 000 output off, 001 held low
// (RL7) codes 010/011 give 2 Hz, 1 Hz square
// (RL8) level codes: second, minute, hour, month
// (RL9) level fall follows seconds increment
// (RL10) 32.000 kHz low phase 0.496 s
// (RL11) trimming corrects period every 20 seconds
// (RL12) falling edge lags increment about 92 us
// (RL13) second control register at Fh, halt state
// (RL14) format bit selects 12 or 24 hour
// (RL15) 12-hour hours: morning 12,01-11, pm bit5
// (RL16) host picks format before writing time
// (RL17) adjust below 30 clears seconds only
// (RL18) adjust from 30 also increments minutes
// (RL19) adjust completes within 122 us
// (RL20) adjust write-only, reads give halt flag
// (RL21) alarm flags cleared only by writing 0; code also clears them on halt and while the alarm enable is 0
// (RL22) level periodic flag cleared by writing 0
// (RL23) control two write clears halt flag
`include "rtcc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rtcc_ctrl
    import rtcc_pkg::*;
(
    input wire logic clk_sys_in,           // 125 MHz system clock
    input wire logic sys_rst_in,           // async reset, active high
    input wire logic osc_clk_in,           // crystal clock, async
    input wire logic osc_halt_in,          // halt detector, async
    input wire logic xtal_lo_sel_in,       // 1: 32.000 kHz crystal
    input wire logic trim_en_in,           // time trimming active
    input wire logic [7:0] trim_step_in,   // signed tick correction
    input wire logic [3:0] reg_addr_in,    // internal address
    input wire logic reg_wr_in,            // write strobe
    input wire logic [7:0] reg_wdata_in,   // write data
    output logic [7:0] reg_rdata_out,      // read data, one cycle late
    input wire rtcc_time_t time_in,        // current counter values
    input wire logic alarm_a_match_in,     // alarm a match pulse
    input wire logic alarm_b_match_in,     // alarm b match pulse
    output logic sec_tick_out,             // seconds increment pulse
    output logic sec_clear_out,            // adjust: seconds to 00
    output logic min_inc_out,              // adjust: minutes plus one
    output logic format_24h_out,           // 1: 24-hour counting
    output logic irq_a_out,                // output a level, open drain
    output logic irq_a_oe_n_out,           // output a enable, low drives
    output logic irq_b_out,                // output b level, open drain
    output logic irq_b_oe_n_out            // output b enable, low drives
);

    // ------------------------------------------------------------
    // derived tick counts
    // ------------------------------------------------------------
    localparam logic [15:0] HALF_HI =
        16'((`RTCC_XTAL_HZ_HI * `RTCC_HALF_MS_HI) / 64'd1000);
    localparam logic [15:0] HALF_LO =
        16'((`RTCC_XTAL_HZ_LO * `RTCC_HALF_MS_LO) / 64'd1000);
    // lag figures are approximate, so round to nearest tick
    localparam logic [15:0] LAG_HI = 16'((`RTCC_XTAL_HZ_HI *
        `RTCC_LAG_NS_HI + 64'd500000000) / 64'd1000000000);
    localparam logic [15:0] LAG_LO = 16'((`RTCC_XTAL_HZ_LO *
        `RTCC_LAG_NS_LO + 64'd500000000) / 64'd1000000000);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic osc_meta_reg, osc_sync_reg, osc_prev_reg, osc_rise;
    logic halt_meta_reg, halt_sync_reg, sec_wrap, lvl_evt, lvl_match;
    logic [15:0] pre_reg, pre_last, half, lag, q1, q2;
    logic [4:0] trim_sec_reg;
    logic in_1hz_low, in_2hz_low, level_mode, wr_ctl1, wr_ctl2, adj_go;
    logic fmt_reg, osc_halt_flag_reg, clkout_disable_reg, periodic_flag_reg, alarm_a_flag_reg, alarm_b_flag_reg;
    logic per_act_reg, per_act_next, a_low, b_low;
    rtcc_ctl1_t ctl1_reg;
    rtcc_ctl2_t wr2;

    // ------------------------------------------------------------
    // synchronisers and crystal edge detect
    // ------------------------------------------------------------
    // the crystal and halt detector are asynchronous to clk_sys_in
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
            halt_meta_reg <= 1'b0;
            halt_sync_reg <= 1'b0;
        end
        else
        begin
            osc_meta_reg <= osc_clk_in;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
            halt_meta_reg <= osc_halt_in;
            halt_sync_reg <= halt_meta_reg;
        end
    end

    assign osc_rise = osc_sync_reg & ~osc_prev_reg;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    assign wr_ctl1 = reg_wr_in && (reg_addr_in == `RTCC_ADDR_CTL1);
    assign wr_ctl2 = reg_wr_in && (reg_addr_in == `RTCC_ADDR_CTL2);
    assign wr2 = rtcc_ctl2_t'(reg_wdata_in);
    assign adj_go = wr_ctl2 && wr2.adj_or_halt;

    // ------------------------------------------------------------
    // sub-second prescaler
    // ------------------------------------------------------------
    // (RL10) phase lengths per crystal
    assign half = xtal_lo_sel_in ? HALF_LO : HALF_HI;
    // (RL12) fall lag behind increment
    assign lag = xtal_lo_sel_in ? LAG_LO : LAG_HI;

    // (RL11) once per 20 s trim term
    always_comb
    begin
        pre_last = xtal_lo_sel_in ? `RTCC_SEC_LAST_LO
                                  : `RTCC_SEC_LAST_HI;
        if (trim_en_in &&
            (trim_sec_reg == `RTCC_TRIM_PERIOD_S - 5'd1))
        begin
            pre_last = pre_last + {{8{trim_step_in[7]}}, trim_step_in};
        end
    end

    assign sec_wrap = osc_rise && (pre_reg == pre_last);
    assign q1 = half >> 1;
    assign q2 = (pre_last + 16'd1 - half) >> 1;

    // prescaler counts crystal edges within the second
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            pre_reg <= 16'h0000;
        // (RL17) adjust clears the prescaler
        else if (adj_go || sec_wrap)
            pre_reg <= 16'h0000;
        else if (osc_rise)
            pre_reg <= pre_reg + 16'd1;
    end

    // counts seconds toward the next trimmed one
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            trim_sec_reg <= 5'd0;
        else if (sec_wrap)
            trim_sec_reg <= (trim_sec_reg == `RTCC_TRIM_PERIOD_S - 5'd1) ?
                            5'd0 : trim_sec_reg + 5'd1;
    end

    // ------------------------------------------------------------
    // counter strobes
    // ------------------------------------------------------------
    // adjust acts at once, far inside its budget; no crystal wait
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sec_tick_out <= 1'b0;
            sec_clear_out <= 1'b0;
            min_inc_out <= 1'b0;
        end
        else
        begin
            sec_tick_out <= sec_wrap && !adj_go;
            // (RL19) adjust completes promptly
            sec_clear_out <= adj_go;
            // (RL18) carry into minutes
            min_inc_out <= adj_go && (time_in.sec >= `RTCC_SEC_HALF);
        end
    end

    // ------------------------------------------------------------
    // periodic waveform generation
    // ------------------------------------------------------------
    // (RL7) square wave windows
    assign in_1hz_low = (pre_reg >= lag) && (pre_reg < half + lag);
    assign in_2hz_low = ((pre_reg >= lag) && (pre_reg < lag + q1)) ||
                        ((pre_reg >= half + lag) &&
                         (pre_reg < half + lag + q2));
    assign level_mode = ctl1_reg.periodic_sel[2];
    // (RL9) level event after increment
    assign lvl_evt = osc_rise && (pre_reg == lag - 16'd1);

    // (RL8) level mode match conditions
    always_comb
    begin
        case (ctl1_reg.periodic_sel)
            RTCC_PER_SEC: lvl_match = 1'b1;
            RTCC_PER_MIN: lvl_match = (time_in.sec == `RTCC_BCD_ZERO7);
            RTCC_PER_HOUR: lvl_match = (time_in.sec == `RTCC_BCD_ZERO7) &&
                           (time_in.min == `RTCC_BCD_ZERO7);
            // (RL15) midnight reads 12 in 12-hour
            RTCC_PER_MONTH: lvl_match = (time_in.sec == `RTCC_BCD_ZERO7) &&
                            (time_in.min == `RTCC_BCD_ZERO7) &&
                            (time_in.day == `RTCC_DAY_FIRST) &&
                            (time_in.hour == (fmt_reg ?
                             `RTCC_HOUR_MID24 : `RTCC_HOUR_MID12));
            default: lvl_match = 1'b0;
        endcase
    end

    // pin state for the periodic source, high means pulled low
    always_comb
    begin
        case (ctl1_reg.periodic_sel)
            // (RL6) off and fixed low
            RTCC_PER_OFF: per_act_next = 1'b0;
            RTCC_PER_LOW: per_act_next = 1'b1;
            RTCC_PER_2HZ: per_act_next = in_2hz_low;
            RTCC_PER_1HZ: per_act_next = in_1hz_low;
            default: per_act_next = periodic_flag_reg;
        endcase
    end

    // ------------------------------------------------------------
    // control register one
    // ------------------------------------------------------------
    // (RL1) halt clears the whole register
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ctl1_reg <= rtcc_ctl1_t'(`RTCC_CTL1_RST);
        else if (halt_sync_reg)
            ctl1_reg <= rtcc_ctl1_t'(`RTCC_CTL1_RST);
        else if (wr_ctl1)
            ctl1_reg <= rtcc_ctl1_t'(reg_wdata_in);
    end

    // ------------------------------------------------------------
    // control register two: format, halt, clock disable
    // ------------------------------------------------------------
    // (RL14) format bit survives a halt on purpose
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            fmt_reg <= 1'b0;
        else if (wr_ctl2)
            fmt_reg <= wr2.fmt_24h;
    end

    // (RL13) halt flag set, clock enabled
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            osc_halt_flag_reg <= 1'b1;
            clkout_disable_reg <= 1'b0;
        end
        else if (halt_sync_reg)
        begin
            osc_halt_flag_reg <= 1'b1;
            clkout_disable_reg <= 1'b0;
        end
        // (RL23) any write clears halt flag
        else if (wr_ctl2)
        begin
            osc_halt_flag_reg <= 1'b0;
            clkout_disable_reg <= wr2.clkout_disable;
        end
    end

    // ------------------------------------------------------------
    // flags: hardware set wins over a software clear
    // ------------------------------------------------------------
    // (RL2) match only counts when enabled
    // (RL21) writing 0 clears, 1 ignored
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            alarm_a_flag_reg <= 1'b0;
            alarm_b_flag_reg <= 1'b0;
        end
        else if (halt_sync_reg)
        begin
            alarm_a_flag_reg <= 1'b0;
            alarm_b_flag_reg <= 1'b0;
        end
        else
        begin
            if (!ctl1_reg.alarm_a_enable)
                alarm_a_flag_reg <= 1'b0;
            else if (alarm_a_match_in)
                alarm_a_flag_reg <= 1'b1;
            else if (wr_ctl2 && !wr2.alarm_a_flag)
                alarm_a_flag_reg <= 1'b0;
            if (!ctl1_reg.alarm_b_enable)
                alarm_b_flag_reg <= 1'b0;
            else if (alarm_b_match_in)
                alarm_b_flag_reg <= 1'b1;
            else if (wr_ctl2 && !wr2.alarm_b_flag)
                alarm_b_flag_reg <= 1'b0;
        end
    end

    // pulse modes mirror the pin; level mode latches the event
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            periodic_flag_reg <= 1'b0;
        else if (halt_sync_reg)
            periodic_flag_reg <= 1'b0;
        else if (!level_mode)
            periodic_flag_reg <= per_act_next;
        else if (lvl_evt && lvl_match)
            periodic_flag_reg <= 1'b1;
        // (RL22) level flag cleared by 0
        else if (wr_ctl2 && !wr2.periodic_flag)
            periodic_flag_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // output routing
    // ------------------------------------------------------------
    // (RL3) routing code selects output b
    assign a_low = alarm_a_flag_reg |
                   (alarm_b_flag_reg & ~ctl1_reg.route_sel_lo) |
                   (per_act_reg & ~ctl1_reg.route_sel_hi);
    assign b_low = (alarm_b_flag_reg & ctl1_reg.route_sel_lo) |
                   (per_act_reg & ctl1_reg.route_sel_hi) |
                   (~osc_sync_reg & ~clkout_disable_reg);

    // open-drain pins only ever drive low; periodic source staged here
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            per_act_reg <= 1'b0;
            irq_a_out <= 1'b0;
            irq_b_out <= 1'b0;
            irq_a_oe_n_out <= 1'b1;
            irq_b_oe_n_out <= 1'b1;
            format_24h_out <= 1'b0;
        end
        else
        begin
            per_act_reg <= per_act_next;
            irq_a_out <= 1'b0;
            irq_b_out <= 1'b0;
            irq_a_oe_n_out <= ~a_low;
            irq_b_oe_n_out <= ~b_low;
            format_24h_out <= fmt_reg;
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    // (RL20) bit 4 returns the halt flag
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= `RTCC_RDATA_RST;
        else if (reg_addr_in == `RTCC_ADDR_CTL1)
            reg_rdata_out <= ctl1_reg;
        else if (reg_addr_in == `RTCC_ADDR_CTL2)
            reg_rdata_out <= {2'b00, fmt_reg, osc_halt_flag_reg, clkout_disable_reg,
                              periodic_flag_reg, alarm_a_flag_reg, alarm_b_flag_reg};
        else
            reg_rdata_out <= `RTCC_RDATA_RST;
    end

endmodule : rtcc_ctrl

`default_nettype wire

// [testbench/rtcc_ctrl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module rtcc_ctrl_monitor
    import rtcc_pkg::*;
(
    input wire logic clk_sys_in,       // clock
    input wire logic sys_rst_in,       // reset
    input wire logic osc_halt_in,      // halt detect
    input wire logic [3:0] reg_addr_in, // address
    input wire logic reg_wr_in,        // write strobe
    input wire logic [7:0] reg_wdata_in, // write data
    input wire logic [7:0] reg_rdata_out, // read data
    input wire rtcc_time_t time_in,    // counters
    input wire logic sec_clear_out,    // seconds to 00
    input wire logic min_inc_out,      // minutes plus one
    input wire logic format_24h_out,   // format copy
    input wire logic irq_a_oe_n_out    // output a enable
);
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    default clocking mon_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    // halt quiet long enough for its synchroniser to settle
    sequence s_osc_ok;
        !osc_halt_in [*4];
    endsequence

    sequence s_wr_ctl2;
        s_osc_ok ##0 (reg_wr_in && reg_addr_in == 4'hf);
    endsequence

    sequence s_adj_wr;
        s_wr_ctl2 ##0 reg_wdata_in[4];
    endsequence

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_rsvd_read_zero: assert property (
        $past(reg_addr_in) == 4'hf |-> reg_rdata_out[7:6] == 2'h0)
        else $error("control two top bits read nonzero");
    a_halt_flag_clear: assert property (
        s_wr_ctl2 ##1 reg_addr_in == 4'hf |=> !reg_rdata_out[4])
        else $error("halt flag still set after write");
    a_adj_low_half: assert property (
        s_adj_wr ##0 time_in.sec < 7'h30 |=> sec_clear_out && !min_inc_out)
        else $error("adjust below thirty wrong");
    a_adj_high_half: assert property (
        s_adj_wr ##0 time_in.sec >= 7'h30 |=> sec_clear_out && min_inc_out)
        else $error("adjust from thirty wrong");
    a_adj_no_cause: assert property (
        !(reg_wr_in && reg_addr_in == 4'hf && reg_wdata_in[4])
        |=> !sec_clear_out && !min_inc_out)
        else $error("adjust pulse without write");
    a_ctl1_readback: assert property (
        s_osc_ok ##0 (reg_wr_in && reg_addr_in == 4'he) ##1
        reg_addr_in == 4'he |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("control one readback differs");
    a_fmt_set: assert property (
        (reg_wr_in && reg_addr_in == 4'hf && reg_wdata_in[5]) ##1
        !(reg_wr_in && reg_addr_in == 4'hf) |=> format_24h_out)
        else $error("format output not set");
    a_low_code_pin: assert property (
        ($past(reg_addr_in) == 4'he && reg_rdata_out == 8'h01) [*3]
        |-> !irq_a_oe_n_out)
        else $error("held low code leaves pin released");
    a_off_code_pin: assert property (
        ($past(reg_addr_in) == 4'he && reg_rdata_out == 8'h00) [*3]
        |-> irq_a_oe_n_out)
        else $error("off code drives pin");
endmodule : rtcc_ctrl_monitor

bind rtcc_ctrl rtcc_ctrl_monitor rtcc_ctrl_monitor_inst (
    .clk_sys_in, .sys_rst_in, .osc_halt_in, .reg_addr_in, .reg_wr_in,
    .reg_wdata_in, .reg_rdata_out, .time_in, .sec_clear_out,
    .min_inc_out, .format_24h_out, .irq_a_oe_n_out
);

`default_nettype wire

// [testbench/rtcc_far_model.sv]
`timescale 1ns/1ps
`default_nettype none

module rtcc_far_model
    import rtcc_pkg::*;
(
    input wire logic clk_sys_in,        // system clock
    input wire logic run_in,            // crystal oscillating
    input wire logic load_in,           // load counters
    input wire rtcc_time_t load_val_in, // value to load
    input wire logic sec_clear_in,      // seconds to 00
    input wire logic min_inc_in,        // minutes plus one
    output logic osc_clk_out,           // crystal clock
    output rtcc_time_t time_out         // counter values
);
    rtcc_time_t time_reg;

    // crystal runs free; offset so its edges keep a fixed phase clear of clock edges
    initial
    begin
        osc_clk_out = 1'b0;
        #3;
        forever
        begin
            #32;
            if (run_in)
                osc_clk_out = ~osc_clk_out;
        end
    end

    // adjust pulses act on the bcd counters, with digit carry
    always_ff @(posedge clk_sys_in)
    begin
        if (load_in)
            time_reg <= load_val_in;
        else if (sec_clear_in)
        begin
            time_reg.sec <= 7'h00;
            if (min_inc_in)
                time_reg.min <= (time_reg.min[3:0] == 4'h9) ?
                    {time_reg.min[6:4] + 3'h1, 4'h0} : time_reg.min + 7'h01;
        end
    end
    assign time_out = time_reg;
endmodule : rtcc_far_model

`default_nettype wire

// [testbench/rtcc_ctrl_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module rtcc_ctrl_tb_top
    import rtcc_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic osc_clk_in, osc_halt_in = 1'b0, run = 1'b1, load = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic alarm_a_match_in = 1'b0, alarm_b_match_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic sec_tick_out, sec_clear_out, min_inc_out, format_24h_out;
    logic irq_a_out, irq_a_oe_n_out, irq_b_out, irq_b_oe_n_out;
    rtcc_time_t time_in, load_val = '0;
    int n_mismatch = 0, checks = 0;

    rtcc_ctrl rtcc_ctrl_inst (
        .clk_sys_in, .sys_rst_in, .osc_clk_in, .osc_halt_in,
        .xtal_lo_sel_in(1'b0), .trim_en_in(1'b0), .trim_step_in(8'h00),
        .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .time_in,
        .alarm_a_match_in, .alarm_b_match_in, .sec_tick_out, .sec_clear_out,
        .min_inc_out, .format_24h_out, .irq_a_out, .irq_a_oe_n_out,
        .irq_b_out, .irq_b_oe_n_out
    );

    rtcc_far_model rtcc_far_model_inst (
        .clk_sys_in, .run_in(run), .load_in(load), .load_val_in(load_val),
        .sec_clear_in(sec_clear_out), .min_inc_in(min_inc_out),
        .osc_clk_out(osc_clk_in), .time_out(time_in)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // 125 MHz system clock
    always #4 clk_sys_in = ~clk_sys_in;

    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : cyc

    // each access waits an edge first so the strobe drops between writes
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        cyc(1);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        cyc(1);
        reg_wr_in = 1'b0;
    endtask : wr

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        cyc(1);
        reg_addr_in = a;
        cyc(1);
        chk(reg_rdata_out, exp);
    endtask : rdchk

    // pin levels stay low; the enables say who pulls a pin down
    task automatic pins(input logic a, input logic b);
        chk({4'h0, irq_a_out, irq_b_out, irq_a_oe_n_out, irq_b_oe_n_out},
            {6'h0, a, b});
    endtask : pins

    task automatic hit(input logic b_sel);
        cyc(1);
        alarm_a_match_in = !b_sel;
        alarm_b_match_in = b_sel;
        cyc(1);
        alarm_a_match_in = 1'b0;
        alarm_b_match_in = 1'b0;
    endtask : hit

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rdchk(4'he, 8'h00);
        rdchk(4'hf, 8'h10);
        rdchk(4'h3, 8'h00);
    endtask : t_reset

    // test bit always written zero, clock output switched off first
    task automatic t_ctl1;
        wr(4'hf, 8'h08);
        for (int c = 0; c < 8; c++)
        begin
            wr(4'he, 8'hc0 | 8'(c));
            rdchk(4'he, 8'hc0 | 8'(c));
        end
        wr(4'he, 8'h01);
        cyc(4);
        pins(1'b0, 1'b1);
        wr(4'he, 8'h00);
        cyc(4);
        pins(1'b1, 1'b1);
    endtask : t_ctl1

    // held-low periodic plus alarm b under every routing code
    task automatic t_route;
        for (int r = 0; r < 4; r++)
        begin
            wr(4'he, 8'h41 | 8'(r << 4));
            hit(1'b1);
            cyc(4);
            pins(r == 3, r == 0);
            wr(4'hf, 8'h08);
        end
    endtask : t_route

    task automatic t_alarm;
        wr(4'he, 8'h80);
        hit(1'b0);
        rdchk(4'hf, 8'h0a);
        pins(1'b0, 1'b1);
        wr(4'hf, 8'h0a);
        rdchk(4'hf, 8'h0a);
        wr(4'hf, 8'h08);
        rdchk(4'hf, 8'h08);
        pins(1'b1, 1'b1);
        wr(4'he, 8'h00);
        hit(1'b0);
        rdchk(4'hf, 8'h08);
    endtask : t_alarm

    task automatic t_format;
        wr(4'hf, 8'h28);
        rdchk(4'hf, 8'h28);
        chk({7'h0, format_24h_out}, 8'h01);
        wr(4'hf, 8'h08);
        cyc(2);
        chk({7'h0, format_24h_out}, 8'h00);
    endtask : t_format

    // seconds either side of the half-minute boundary
    task automatic t_adjust;
        logic [6:0] s;
        for (int i = 0; i < 2; i++)
        begin
            s = i ? 7'h30 : 7'h29;
            cyc(1);
            load_val = '{sec: s, min: 7'h19, hour: 6'h08, day: 6'h01};
            load = 1'b1;
            cyc(1);
            load = 1'b0;
            wr(4'hf, 8'h18);
            cyc(3);
            chk({1'b0, time_in.sec}, 8'h00);
            chk({1'b0, time_in.min}, i ? 8'h20 : 8'h19);
            rdchk(4'hf, 8'h08);
        end
    endtask : t_adjust

    // adjust zeroes the prescaler, so the pulse phase is known
    task automatic t_pulse;
        for (int c = 2; c < 4; c++)
        begin
            wr(4'he, 8'(c));
            wr(4'hf, 8'h18);
            cyc(3);
            pins(1'b1, 1'b1);
            cyc(60);
            pins(1'b0, 1'b1);
            rdchk(4'hf, 8'h0c);
        end
    endtask : t_pulse

    task automatic t_halt;
        wr(4'he, 8'h47);
        wr(4'hf, 8'h28);
        cyc(1);
        osc_halt_in = 1'b1;
        run = 1'b0;
        cyc(6);
        osc_halt_in = 1'b0;
        run = 1'b1;
        cyc(6);
        rdchk(4'he, 8'h00);
        rdchk(4'hf, 8'h30);
    endtask : t_halt

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        cyc(8);
        sys_rst_in = 1'b0;
        load = 1'b0;
        t_reset;
        t_ctl1;
        t_route;
        t_alarm;
        t_format;
        t_adjust;
        t_pulse;
        t_halt;
        close_out;
    end

    // run needs about 300 cycles; allow far more
    initial
    begin
        #100000;
        n_mismatch++;
        close_out;
    end
endmodule : rtcc_ctrl_tb_top

`default_nettype wire
